/* rtl/pnsb_port.sv */
// Synchronous command port of a pipelined no-wait burst SRAM, x36 organisation
// Overview of operation
// - Advance high keeps deselect, but only after a real deselect cycle.
// - Selected, advance low, read select high: load address, start burst read.
// - Advance high in a read burst reads the next burst address.
// - Read start with output enable high is a dummy read, pins undriven.
// - Advance high with output enable high advances as a dummy read.
// - Selected, advance low, read select low, lanes enabled: start burst write.
// - Advance high in a write burst writes next address with enabled lanes.
// - Write start with all lane enables high is an accepted write abort.
// - Advance high with all lanes high advances without changing memory.
// - Clock gate high: all synchronous inputs ignored, state held.
// - Read select low means write, high means read; lanes ignored on reads.
// - Four active-low lane enables each gate one byte lane in x36.
// - Wider organisations use one enable per lane; here fixed at four.
// - Sleep request high floats all data pins regardless of output enable.
// - Read data driven only while output enable and sleep are both low.
// - Deselected and awake: data pins float once any read in flight has drained.
// - Interleaved order: low bits are seed XOR 01, 10, then 11.
// - Burst order select low chooses linear order.
`timescale 1ns/1ns
`default_nettype none
module pnsb_port (
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic                        clockGate,
    input  wire logic                        chipSelectLowB,
    input  wire logic                        chipSelectLow2B,
    input  wire logic                        chipSelectHigh,
    input  wire logic                        loadAdvance,
    input  wire logic                        readSelect,
    input  wire logic [pnsb_pkg::LANES-1:0]  byteWriteLaneN,
    input  wire logic [pnsb_pkg::ADDR_W-1:0] addrIn,
    input  wire logic                        burstOrderInterleaved,
    input  wire logic                        outputEnableN,
    input  wire logic                        sleepRequest,
    input  wire logic [pnsb_pkg::DATA_W-1:0] dataLanesIn,
    output logic      [pnsb_pkg::DATA_W-1:0] dataLanesOut,
    output logic                             dataLanesOeN,
    output logic                             deselected
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rstSyncQ;
    logic       rstSyncN;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstSyncQ <= pnsb_pkg::SYNC_RST;
        end else begin
            rstSyncQ <= {rstSyncQ[0], 1'b1};
        end
    end
    assign rstSyncN = rstSyncQ[1];

    // ************************************************************
    // Command decode
    // ************************************************************
    logic                 clkOn;
    logic                 selAll;
    logic                 cmdLoad;
    logic                 cmdDesel;
    logic                 cmdRead;
    logic                 cmdWrite;
    logic                 cmdAdv;
    logic                 laneAny;
    pnsb_pkg::pnsb_state_e stateQ;
    pnsb_pkg::pnsb_state_e stateD;

    assign clkOn    = !clockGate;
    assign selAll   = !chipSelectLowB && !chipSelectLow2B && chipSelectHigh;
    assign cmdLoad  = clkOn && !loadAdvance;
    assign cmdDesel = cmdLoad && !selAll;
    assign cmdRead  = cmdLoad && selAll && readSelect;
    assign cmdWrite = cmdLoad && selAll && !readSelect;
    assign laneAny  = !(&byteWriteLaneN);
    assign cmdAdv   = clkOn && loadAdvance &&
                      (stateQ == pnsb_pkg::PNSB_READ || stateQ == pnsb_pkg::PNSB_WRITE);

    // ************************************************************
    // Operation state
    // ************************************************************
    always_comb begin
        stateD = stateQ;
        if (cmdDesel) begin
            stateD = pnsb_pkg::PNSB_DESEL;
        end else if (cmdRead) begin
            stateD = pnsb_pkg::PNSB_READ;
        end else if (cmdWrite) begin
            stateD = pnsb_pkg::PNSB_WRITE;
        end else begin
            // Advance keeps read, write or deselect; idle only leaves via a load
            case (stateQ)
                pnsb_pkg::PNSB_IDLE:  stateD = pnsb_pkg::PNSB_IDLE;
                pnsb_pkg::PNSB_DESEL: stateD = pnsb_pkg::PNSB_DESEL;
                pnsb_pkg::PNSB_READ:  stateD = pnsb_pkg::PNSB_READ;
                pnsb_pkg::PNSB_WRITE: stateD = pnsb_pkg::PNSB_WRITE;
                default:              stateD = pnsb_pkg::PNSB_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stateQ <= pnsb_pkg::PNSB_IDLE;
        end else begin
            stateQ <= stateD;
        end
    end

    // ************************************************************
    // Address register and burst counter
    // ************************************************************
    logic [pnsb_pkg::ADDR_W-1:0] addrQ;
    logic [pnsb_pkg::ADDR_W-1:0] addrD;
    logic [1:0]                  burstBits;
    logic [pnsb_pkg::ADDR_W-1:0] curAddr;
    logic                        burstLoad;

    assign burstLoad = cmdRead || cmdWrite;

    always_comb begin
        addrD = addrQ;
        if (burstLoad) begin
            addrD = addrIn;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            addrQ <= '0;
        end else begin
            addrQ <= addrD;
        end
    end

    pnsb_burst_ctr pnsb_burst_ctr_inst (
        .ref_clk              (ref_clk),
        .rstSyncN             (rstSyncN),
        .load                 (burstLoad),
        .advance              (cmdAdv),
        .seedBits             (addrIn[1:0]),
        .burstOrderInterleaved(burstOrderInterleaved),
        .burstBits            (burstBits)
    );

    // Upper bits stay as loaded; only the low two follow the counter
    assign curAddr = {addrQ[pnsb_pkg::ADDR_W-1:2], burstBits};

    // ************************************************************
    // Two-stage pipeline
    // ************************************************************
    // Stage one: the address phase after the command edge
    logic                        s1RdQ;
    logic                        s1RdD;
    logic                        s1WrQ;
    logic                        s1WrD;
    logic [pnsb_pkg::LANES-1:0]  s1LaneQ;
    logic [pnsb_pkg::LANES-1:0]  s1LaneD;
    logic                        s2RdQ;
    logic                        s2RdD;
    logic                        opActive;

    assign opActive = cmdAdv || burstLoad;

    always_comb begin
        s1RdD   = s1RdQ;
        s1WrD   = s1WrQ;
        s1LaneD = s1LaneQ;
        s2RdD   = s2RdQ;
        if (clkOn) begin
            s1RdD   = opActive && (cmdRead || (cmdAdv && stateQ == pnsb_pkg::PNSB_READ));
            s1WrD   = opActive && (cmdWrite || (cmdAdv && stateQ == pnsb_pkg::PNSB_WRITE)) && laneAny;
            s1LaneD = ~byteWriteLaneN;
            s2RdD   = s1RdQ;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s1RdQ   <= 1'b0;
            s1WrQ   <= 1'b0;
            s1LaneQ <= '0;
            s2RdQ   <= 1'b0;
        end else begin
            s1RdQ   <= s1RdD;
            s1WrQ   <= s1WrD;
            s1LaneQ <= s1LaneD;
            s2RdQ   <= s2RdD;
        end
    end

    // Address is captured per command so stage one uses the one in flight
    logic [pnsb_pkg::ADDR_W-1:0] s1AddrQ;
    logic [pnsb_pkg::ADDR_W-1:0] s1AddrD;
    logic [pnsb_pkg::ADDR_W-1:0] nextAddr;

    assign nextAddr = burstLoad ? addrIn : curAddr;

    always_comb begin
        s1AddrD = s1AddrQ;
        if (clkOn && opActive) begin
            s1AddrD = cmdAdv ? curAddr : nextAddr;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s1AddrQ <= '0;
        end else begin
            s1AddrQ <= s1AddrD;
        end
    end

    // ************************************************************
    // Memory
    // ************************************************************
    // Write data arrive on the second edge, so the write fires from stage one
    logic [pnsb_pkg::DATA_W-1:0] rdData;

    pnsb_mem pnsb_mem_inst (
        .ref_clk(ref_clk),
        .rdEn   (clkOn && s1RdQ),
        .wrEn   (clkOn && s1WrQ),
        .addr   (s1AddrQ),
        .laneWr (s1LaneQ),
        .wrData (dataLanesIn),
        .rdData (rdData)
    );

    assign dataLanesOut = rdData;

    // ************************************************************
    // Asynchronous output control
    // ************************************************************
    // Drive only during valid read data; sleep and output enable act at once
    assign dataLanesOeN = !(s2RdQ && !outputEnableN && !sleepRequest);
    assign deselected   = (stateQ == pnsb_pkg::PNSB_DESEL);

    // ************************************************************
    // Checks
    // ************************************************************
    sequence readCmd_s;
        clkOn && cmdRead;
    endsequence

    desel_enter_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        cmdDesel |=> deselected)
        else $error("deselect not entered");
    desel_hold_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (clkOn && loadAdvance && !deselected && stateQ != pnsb_pkg::PNSB_DESEL) |=> !deselected)
        else $error("continue deselect without deselect");
    read_lat_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        readCmd_s ##1 clkOn |=> s2RdQ)
        else $error("read pipeline latency wrong");
    gate_hold_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        clockGate |=> ($stable(stateQ) && $stable(addrQ) && $stable(s2RdQ)))
        else $error("state moved on gated edge");
    sleep_float_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        sleepRequest |-> dataLanesOeN)
        else $error("drive during sleep");
    oe_float_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        outputEnableN |-> dataLanesOeN)
        else $error("drive with output enable high");
    abort_nowr_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (clkOn && cmdWrite && !laneAny) |=> !s1WrQ)
        else $error("write abort wrote memory");
    load_addr_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (clkOn && burstLoad) |=> (s1AddrQ == $past(addrIn)))
        else $error("address not loaded");
    desel_float_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        (deselected && $past(deselected) && $past(clkOn)) |-> dataLanesOeN)
        else $error("drive while deselected");
endmodule
`default_nettype wire

/* rtl/pnsb_pkg.sv */
// Package of constants and types for the pipelined no-wait SRAM bus port
package pnsb_pkg;
    localparam int unsigned ADDR_W    = 19;
    localparam int unsigned LANES     = 4;
    localparam int unsigned LANE_W    = 9;
    localparam int unsigned DATA_W    = LANES * LANE_W;
    localparam int unsigned DEPTH     = 1 << ADDR_W;
    localparam int unsigned PIPE_LAT  = 2;
    localparam logic [1:0]  BURST_ONE = 2'h1;
    localparam logic [1:0]  SYNC_RST  = 2'h0;

    typedef enum logic [3:0] {
        PNSB_IDLE  = 4'h1,
        PNSB_DESEL = 4'h2,
        PNSB_READ  = 4'h4,
        PNSB_WRITE = 4'h8
    } pnsb_state_e;
endpackage

/* rtl/pnsb_burst_ctr.sv */
// Two-bit burst counter with interleaved and linear orders
`timescale 1ns/1ns
`default_nettype none
module pnsb_burst_ctr (
    input  wire logic       ref_clk,
    input  wire logic       rstSyncN,
    input  wire logic       load,
    input  wire logic       advance,
    input  wire logic [1:0] seedBits,
    input  wire logic       burstOrderInterleaved,
    output logic      [1:0] burstBits
);
    logic [1:0] seedQ;
    logic [1:0] seedD;
    logic [1:0] stepQ;
    logic [1:0] stepD;
    logic [1:0] stepNext;

    always_comb begin
        seedD = seedQ;
        stepD = stepQ;
        if (load) begin
            seedD = seedBits;
            stepD = 2'h0;
        end else if (advance) begin
            stepD = stepQ + pnsb_pkg::BURST_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            seedQ <= pnsb_pkg::SYNC_RST;
            stepQ <= pnsb_pkg::SYNC_RST;
        end else begin
            seedQ <= seedD;
            stepQ <= stepD;
        end
    end

    // Shows the address of the coming advance, so the first advance already lands on beat one
    assign stepNext  = stepQ + pnsb_pkg::BURST_ONE;
    // Interleaved XORs the step in, linear adds it and wraps modulo four
    assign burstBits = burstOrderInterleaved ? (seedQ ^ stepNext) : (seedQ + stepNext);
endmodule
`default_nettype wire

/* rtl/pnsb_mem.sv */
// Byte-lane write memory array with registered read data
`timescale 1ns/1ns
`default_nettype none
module pnsb_mem (
    input  wire logic                        ref_clk,
    input  wire logic                        rdEn,
    input  wire logic                        wrEn,
    input  wire logic [pnsb_pkg::ADDR_W-1:0] addr,
    input  wire logic [pnsb_pkg::LANES-1:0]  laneWr,
    input  wire logic [pnsb_pkg::DATA_W-1:0] wrData,
    output logic      [pnsb_pkg::DATA_W-1:0] rdData
);
    logic [pnsb_pkg::DATA_W-1:0] store [pnsb_pkg::DEPTH];

    // One process owns the array; per-lane processes would each drive the whole word
    always_ff @(posedge ref_clk) begin
        for (int g = 0; g < pnsb_pkg::LANES; g++) begin
            if (wrEn && laneWr[g]) begin
                store[addr][g*pnsb_pkg::LANE_W +: pnsb_pkg::LANE_W] <=
                    wrData[g*pnsb_pkg::LANE_W +: pnsb_pkg::LANE_W];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rdEn) begin
            rdData <= store[addr];
        end
    end
endmodule
`default_nettype wire

/* verification/pnsb_ctrl_model.sv */
// Controller model that drives the synchronous bus of the SRAM port
`timescale 1ns/1ns
`default_nettype none
module pnsb_ctrl_model (
    input  wire logic        ref_clk,
    output logic             clockGate,
    output logic             chipSelectLowB,
    output logic             chipSelectLow2B,
    output logic             chipSelectHigh,
    output logic             loadAdvance,
    output logic             readSelect,
    output logic [3:0]       byteWriteLaneN,
    output logic [18:0]      addrIn,
    output logic             burstOrderInterleaved,
    output logic             outputEnableN,
    output logic             sleepRequest,
    output logic [35:0]      dataLanesIn
);
    initial begin
        {clockGate, loadAdvance, readSelect} = 3'h2;
        {chipSelectLowB, chipSelectLow2B, chipSelectHigh} = 3'h1;
        byteWriteLaneN = 4'hF;
        addrIn = 19'h0;
        burstOrderInterleaved = 1'b1;
        outputEnableN = 1'b1;
        sleepRequest = 1'b0;
        dataLanesIn = 36'h0;
    end

    task automatic setAsync(input logic oe, input logic zz, input logic md);
        @(posedge ref_clk);
        outputEnableN <= oe;
        sleepRequest <= zz;
        burstOrderInterleaved <= md;
    endtask

    task automatic cyc(input logic g, input logic ld, input logic rs, input logic [2:0] sel,
                       input logic [3:0] ln, input logic [18:0] a, input logic wv, input logic [35:0] wd);
        @(posedge ref_clk);
        clockGate <= g;
        loadAdvance <= ld;
        readSelect <= rs;
        {chipSelectLowB, chipSelectLow2B, chipSelectHigh} <= sel;
        byteWriteLaneN <= ln;
        addrIn <= a;
        if (wv) begin
            outputEnableN <= 1'b1;
            dataLanesIn <= wd;
        end else begin
            // Bus not owned: toggle so a stale word never passes as valid
            dataLanesIn <= ~dataLanesIn;
        end
    endtask
endmodule
`default_nettype wire

/* verification/tb_pipelined_nowait_sram_bus_port.sv */
// Self-checking testbench for the pipelined no-wait SRAM bus port
`timescale 1ns/1ns
`default_nettype none
module tb_pipelined_nowait_sram_bus_port;
    localparam logic [2:0] SEL_ON  = 3'h1;
    localparam logic [2:0] SEL_OFF = 3'h4;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clockGate, csLowB, csLow2B, csHigh, loadAdvance, readSelect;
    logic [3:0]  byteWriteLaneN;
    logic [18:0] addrIn;
    logic        burstOrderInterleaved, outputEnableN, sleepRequest, dataLanesOeN, deselected;
    logic [35:0] dataLanesIn, dataLanesOut;
    logic [35:0] shadow [logic [18:0]];
    int          fails = 0;
    int          num_checks = 0;

    always #5 ref_clk = ~ref_clk;

    pnsb_ctrl_model pnsb_ctrl_model_inst (.ref_clk(ref_clk), .clockGate(clockGate), .chipSelectLowB(csLowB),
        .chipSelectLow2B(csLow2B), .chipSelectHigh(csHigh), .loadAdvance(loadAdvance), .readSelect(readSelect),
        .byteWriteLaneN(byteWriteLaneN), .addrIn(addrIn), .burstOrderInterleaved(burstOrderInterleaved),
        .outputEnableN(outputEnableN), .sleepRequest(sleepRequest), .dataLanesIn(dataLanesIn));

    pnsb_port pnsb_port_inst (.ref_clk(ref_clk), .resetn(resetn), .clockGate(clockGate), .chipSelectLowB(csLowB),
        .chipSelectLow2B(csLow2B), .chipSelectHigh(csHigh), .loadAdvance(loadAdvance), .readSelect(readSelect),
        .byteWriteLaneN(byteWriteLaneN), .addrIn(addrIn), .burstOrderInterleaved(burstOrderInterleaved),
        .outputEnableN(outputEnableN), .sleepRequest(sleepRequest), .dataLanesIn(dataLanesIn),
        .dataLanesOut(dataLanesOut), .dataLanesOeN(dataLanesOeN), .deselected(deselected));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [35:0] seen, input logic [35:0] expd);
        num_checks++;
        if (seen !== expd) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask

    function automatic logic [18:0] baddr(input logic [18:0] b, input logic md, input int k);
        baddr = md ? {b[18:2], b[1:0] ^ 2'(k)} : {b[18:2], b[1:0] + 2'(k)};
    endfunction

    // Every lane of every beat distinct, so a swapped lane or beat shows
    function automatic logic [143:0] mk(input logic [7:0] s);
        for (int k = 0; k < 16; k++)
            mk[9*k +: 9] = {s, 1'b0} + 9'(k);
    endfunction

    task automatic write_burst(input logic [18:0] b, input logic md, input logic [15:0] lns, input logic [143:0] ds);
        logic [18:0] a;
        pnsb_ctrl_model_inst.setAsync(1'b1, 1'b0, md);
        for (int i = 0; i < 5; i++)
            pnsb_ctrl_model_inst.cyc(1'b0, i inside {[1:3]}, 1'b0, i < 4 ? SEL_ON : SEL_OFF, lns[4*(i%4) +: 4], b,
                                     i > 0, ds[36*((i+3)%4) +: 36]);
        for (int k = 0; k < 4; k++) begin
            a = baddr(b, md, k);
            for (int g = 0; g < 4; g++)
                if (!lns[4*k+g])
                    shadow[a][9*g +: 9] = ds[36*k+9*g +: 9];
        end
    endtask

    task automatic read_burst(input logic [18:0] b, input logic md, input int n, input logic oe, input logic zz);
        pnsb_ctrl_model_inst.setAsync(oe, zz, md);
        for (int i = 0; i < n + 3; i++) begin
            pnsb_ctrl_model_inst.cyc(1'b0, i != 0 && i < n, 1'b1, i < n ? SEL_ON : SEL_OFF, 4'h0, b, 1'b0, 36'h0);
            #1;
            if (oe | zz)
                chk(36'(dataLanesOeN), 36'h1);
            else if (i >= 2 && i < n + 2) begin
                chk(dataLanesOut, shadow[baddr(b, md, i - 2)]);
                chk(36'(dataLanesOeN), 36'h0);
            end else if (i == n + 2)
                chk(36'(dataLanesOeN), 36'h1);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_desel();
        logic [2:0] pats [3] = '{3'h4, 3'h2, 3'h0};
        pnsb_ctrl_model_inst.setAsync(1'b0, 1'b0, 1'b1);
        pnsb_ctrl_model_inst.cyc(1'b0, 1'b1, 1'b1, SEL_ON, 4'h0, 19'h0, 1'b0, 36'h0);
        pnsb_ctrl_model_inst.cyc(1'b0, 1'b1, 1'b1, SEL_ON, 4'h0, 19'h0, 1'b0, 36'h0);
        #1;
        chk(36'(deselected), 36'h0);
        foreach (pats[p]) begin
            pnsb_ctrl_model_inst.cyc(1'b0, 1'b0, 1'b0, SEL_ON, 4'hF, 19'h0, 1'b0, 36'h0);
            pnsb_ctrl_model_inst.cyc(1'b0, 1'b0, 1'b1, pats[p], 4'h0, 19'h0, 1'b0, 36'h0);
            for (int j = 0; j < 2; j++) begin
                pnsb_ctrl_model_inst.cyc(1'b0, 1'b1, 1'b0, SEL_ON, 4'h0, 19'h0, 1'b0, 36'h0);
                #1;
                chk(36'(deselected), 36'h1);
                chk(36'(dataLanesOeN), 36'h1);
            end
        end
        $display("test deselect done");
    endtask

    task automatic t_orders();
        write_burst(19'h00012, 1'b1, 16'h0000, mk(8'h11));
        write_burst(19'h00107, 1'b0, 16'h0000, mk(8'h22));
        read_burst(19'h00011, 1'b0, 4, 1'b0, 1'b0);
        read_burst(19'h00104, 1'b1, 4, 1'b0, 1'b0);
        $display("test burst orders done");
    endtask

    task automatic t_lanes();
        write_burst(19'h00200, 1'b0, 16'h0000, mk(8'h33));
        write_burst(19'h00200, 1'b1, 16'h7BDE, mk(8'h44));
        write_burst(19'h00201, 1'b0, 16'h0F0F, mk(8'h55));
        read_burst(19'h00200, 1'b0, 4, 1'b0, 1'b0);
        $display("test byte lanes done");
    endtask

    // A gated edge carries a write to the word being read; it must leave no trace
    task automatic t_gate();
        read_burst(19'h00200, 1'b1, 1, 1'b0, 1'b0);
        pnsb_ctrl_model_inst.cyc(1'b0, 1'b0, 1'b1, SEL_ON, 4'h0, 19'h00201, 1'b0, 36'h0);
        pnsb_ctrl_model_inst.cyc(1'b1, 1'b0, 1'b0, SEL_ON, 4'h0, 19'h00201, 1'b0, 36'h0);
        for (int i = 0; i < 3; i++) begin
            pnsb_ctrl_model_inst.cyc(1'b0, 1'b0, 1'b1, SEL_OFF, 4'h0, 19'h0, 1'b0, 36'h0);
            #1;
            chk(dataLanesOut, shadow[i < 1 ? 19'h00200 : 19'h00201]);
        end
        read_burst(19'h00201, 1'b1, 1, 1'b0, 1'b0);
        $display("test clock gate done");
    endtask

    task automatic t_async();
        read_burst(19'h00104, 1'b1, 4, 1'b1, 1'b0);
        read_burst(19'h00104, 1'b0, 4, 1'b0, 1'b1);
        read_burst(19'h00104, 1'b1, 2, 1'b1, 1'b1);
        read_burst(19'h00106, 1'b0, 4, 1'b0, 1'b0);
        $display("test output drive done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_desel();
        t_orders();
        t_lanes();
        t_gate();
        t_async();
        report_and_stop();
    end

    // Whole run is about 120 cycles; this leaves wide margin
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
